// >>> testbench/testbench.sv
// Self-checking bench of the transmit interrupt status block
`timescale 1ns/1ns
module testbench;
  import tx_irq_pkg::*;
  logic        clk = 0, reset_n = 0, irq, no_crc, rx_rst;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [5:0]  pl;
  logic [2:0]  lv;
  int          bad_count = 0, n_tests = 0, cyc = 0;
  always #5 clk = ~clk;
  tx_path_model pm (.clk(clk), .pulse_o(pl), .level_o(lv));
  tx_interrupt_status #(.CNT_W(16)) dut_u (.clk(clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .channel_busy(lv[0]), .antenna_slot_end(pl[0]), .third_irq_active(lv[1]),
    .tx_byte_sent(pl[1]), .tx_last_data_bit(pl[2]), .tx_crc_first_bit(pl[3]),
    .tx_crc_last_bit(pl[4]), .delimiter_sent(pl[5]), .tx_fifo_full(lv[2]),
    .irq(irq), .no_tx_crc(no_crc), .receive_reset(rx_rst));
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Handshakes are sampled at the falling edge, where nothing is moving
  // An edge passes after each transfer so a following call never re-drives a strobe at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] eb = 2'h0, input logic [3:0] st = 4'hF);
    logic       ta, tw, hs;
    logic [1:0] br;
    awaddr <= a; wdata <= d; wstrb <= st; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(negedge clk); ta = awvalid & awready; tw = wvalid & wready; hs = bvalid;
      br = bresp;
      @(posedge clk); if (ta) awvalid <= 0; if (tw) wvalid <= 0;
    end while (!hs);
    bready <= 0;
    chk("bresp", {30'h0, eb}, {30'h0, br});
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic ta, hs;
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(negedge clk); ta = arvalid & arready; hs = rvalid;
      if (hs) chk("rdata", e, rdata);
      if (hs) chk("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge clk); if (ta) arvalid <= 0;
    end while (!hs);
    rready <= 0;
    @(posedge clk);
  endtask
  task automatic pin(input string nm, const ref logic s, input logic e);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(nm, {31'h0, e}, {31'h0, s});
    @(posedge clk);
  endtask
  // Reset values, a write with lane 0 off, and an unmapped place
  task t_reset;
    rd(8'h00, 32'h21);
    rd(8'h04, 32'h00);
    rd(8'h0C, 32'hFFFF);
    rd(8'h14, 32'h00, RESP_SLVERR);
    wr(8'h04, 32'hFF, RESP_OKAY, 4'hE);
    rd(8'h04, 32'h00);
    wr(8'h14, 32'hFF, RESP_SLVERR);
  endtask
  // Events one after another, all but the byte and last data bit pulses, then zero and one writes; busy toggles both ways
  task t_events;
    pm.level(0, 1'b1);
    foreach (pl[k]) if (k != 1 && k != 2) pm.pulse(k);
    rd(8'h00, 32'hEF);
    wr(8'h00, 32'h00);
    rd(8'h00, 32'hEF);
    wr(8'h00, 32'hEF);
    rd(8'h00, 32'h21);
    pm.level(0, 1'b0);
    rd(8'h00, 32'hA1);
  endtask
  // Interrupt follows set bits only where unmasked; summary has its own unmask
  task t_mask;
    pin("irq", irq, 1'b0);
    wr(8'h04, 32'h80);
    pin("irq", irq, 1'b1);
    wr(8'h00, 32'h80);
    pin("irq", irq, 1'b0);
    wr(8'h04, 32'h20);
    pin("irq", irq, 1'b1);
    pm.level(1, 1'b0);
    pin("irq", irq, 1'b0);
    rd(8'h00, 32'h01);
    wr(8'h04, 32'h00);
    pm.level(1, 1'b1);
  endtask
  // Checksum switched off, then receive reset against the slot bit
  task t_ctrl;
    wr(8'h08, 32'h02);
    pin("no_crc", no_crc, 1'b1);
    pm.pulse(3);
    pm.pulse(2);
    rd(8'h00, 32'h29);
    pm.pulse(0);
    rd(8'h00, 32'h69);
    wr(8'h08, 32'h01);
    pin("rx_reset", rx_rst, 1'b1);
    rd(8'h00, 32'h29);
    wr(8'h08, 32'h00);
    wr(8'h00, 32'h08);
  endtask
  // Limit of three bytes; counting goes on past it; a full fifo drops bit 0
  task t_count;
    wr(8'h0C, 32'h03);
    repeat (2) pm.pulse(1);
    rd(8'h00, 32'h21);
    pm.pulse(1);
    rd(8'h00, 32'h31);
    pm.pulse(1);
    rd(8'h10, 32'h04);
    pm.level(2, 1'b1);
    rd(8'h00, 32'h30);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // A hang ends in the same report, counted as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      summarize;
    end
  end
  initial begin
    awaddr <= 8'h00;
    araddr <= 8'h00;
    wdata <= 32'h0000_0000;
    wstrb <= 4'hF;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_events;
    t_mask;
    t_ctrl;
    t_count;
    summarize;
  end
endmodule

// >>> testbench/tx_irq_monitor.sv
// Checker of bus answers, interrupt gating and control outputs
`timescale 1ns/1ns
module tx_irq_monitor
  import tx_irq_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq,
  input wire logic        no_tx_crc,
  input wire logic        receive_reset
);
  logic       aw_t;
  logic       ar_t;
  logic       ok_a;
  logic [7:0] um_r;
  logic [1:0] ctl_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Handshakes; the bench offers address and data together
  assign aw_t = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign ar_t = s_axi_arvalid && s_axi_arready;
  assign ok_a = s_axi_araddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  // Shadows of unmask and control, so outputs can be tied to what was written
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      um_r <= 8'h00;
      ctl_r <= 2'h0;
    end else if (aw_t && s_axi_wstrb[0] && s_axi_awaddr == 8'h04) begin
      um_r <= s_axi_wdata[7:0];
    end else if (aw_t && s_axi_wstrb[0] && s_axi_awaddr == 8'h08) begin
      ctl_r <= s_axi_wdata[1:0];
    end
  end
  // The slave registers address and data first, so the answer comes two edges on
  a_write_answer: assert property (aw_t |-> ##2 s_axi_bvalid) else $error("no write response");
  a_read_answer: assert property (ar_t |=> s_axi_rvalid) else $error("no read response");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_read_code: assert property (ar_t |=> s_axi_rresp == ($past(ok_a) ? RESP_OKAY : RESP_SLVERR))
    else $error("wrong read response code");
  a_unmapped_zero: assert property (ar_t && !ok_a |=> s_axi_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_masked_quiet: assert property ((um_r == 8'h00) [*3] |-> !irq)
    else $error("interrupt with all bits masked");
  a_ctrl_follow: assert property (aw_t && s_axi_awaddr == 8'h08 |->
    ##[1:2] {no_tx_crc, receive_reset} == ctl_r) else $error("control outputs wrong");
endmodule
bind tx_interrupt_status tx_irq_monitor mon_u (.*);

// >>> testbench/tx_path_model.sv
// Stand-in for the transmit datapath: event pulses and status levels
`timescale 1ns/1ns
module tx_path_model (
  input  wire logic       clk,
  output logic      [5:0] pulse_o,
  output logic      [2:0] level_o
);
  // Pulses: 0 slot end, 1 byte, 2 last bit, 3 crc first, 4 crc last, 5 delimiter
  // Levels: 0 busy, 1 third register active, 2 fifo full
  initial begin
    pulse_o = 6'h00;
    level_o = 3'h2;
  end
  // One-cycle pulse; a second call waits an edge so strobes never merge
  task automatic pulse(input int k);
    pulse_o[k] <= 1'b1;
    @(posedge clk);
    pulse_o[k] <= 1'b0;
    @(posedge clk);
  endtask
  task automatic level(input int k, input logic v);
    level_o[k] <= v;
    @(posedge clk);
  endtask
endmodule

// >>> verilog/tx_interrupt_status.sv
// Transmit interrupt status register with unmask, byte counter and AXI4-Lite slave
// Functional notes
// - Writing one clears that status bit, except live bits 5 and 0
// - Writing zero leaves status bit unchanged
// - Masked bits still set, raise no interrupt
// - Interrupt only where unmask bit is one; unmask resets zero
// - Bit 7 sets on any busy change
// - Bit 6 sets at each antenna slot end
// - Receive reset also clears bit 6
// - Bit 5 set when third register active; resets one
// - Summary ignores receive interrupt register
// - Summary has its own unmask bit
// - Bit 4 sets when byte count hits limit
// - Count limit never stops transmission
// - Bit 3 sets after checksum fully sent
// - Without CRC, bit 3 sets after last data bit
// - Bit 2 sets at first CRC bit out
// - Without CRC, bit 2 never sets
// - Bit 1 sets when start delimiter sent
// - Bit 0 shows FIFO not full; resets one
`timescale 1ns/1ns
module tx_interrupt_status
  import tx_irq_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Transmit datapath events, same clock domain
  input  wire logic        channel_busy,
  input  wire logic        antenna_slot_end,
  input  wire logic        third_irq_active,
  input  wire logic        tx_byte_sent,
  input  wire logic        tx_last_data_bit,
  input  wire logic        tx_crc_first_bit,
  input  wire logic        tx_crc_last_bit,
  input  wire logic        delimiter_sent,
  input  wire logic        tx_fifo_full,
  output logic             irq,
  output logic             no_tx_crc,
  output logic             receive_reset
);

  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic [1:0] rst_sync_r;
  logic       rst_n;

  // Entry into reset is immediate; leaving it waits two edges so that
  // every flop below comes out of reset on the same clock edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0]       status_r;
  logic [7:0]       status_nxt;
  logic [7:0]       unmask_r;
  logic [1:0]       control_r;
  logic [CNT_W-1:0] limit_r;
  logic [CNT_W-1:0] count_r;
  logic             busy_d_r;
  logic [7:0]       aw_addr_r;
  logic [31:0]      w_data_r;
  logic [3:0]       w_strb_r;
  logic             aw_have_r;
  logic             w_have_r;
  logic             ar_busy_r;

  // ****************************************
  // Bus write path
  // ****************************************
  // Address and data are caught separately so either may come first
  // Nothing new is taken while a response waits, so a held write is never overwritten
  wire   aw_take  = s_axi_awvalid && !aw_have_r && !s_axi_bvalid;
  wire   w_take   = s_axi_wvalid && !w_have_r && !s_axi_bvalid;
  wire   wr_fire  = aw_have_r && w_have_r && !s_axi_bvalid;
  wire   wr_lane0 = wr_fire && w_strb_r[0];
  wire   wr_lane1 = wr_fire && w_strb_r[1];
  wire   hit_stat = aw_addr_r[7:2] == STATUS_OFFSET[7:2];
  wire   hit_umsk = aw_addr_r[7:2] == UNMASK_OFFSET[7:2];
  wire   hit_ctrl = aw_addr_r[7:2] == CONTROL_OFFSET[7:2];
  wire   hit_lim  = aw_addr_r[7:2] == LIMIT_OFFSET[7:2];
  wire   hit_cnt  = aw_addr_r[7:2] == COUNT_OFFSET[7:2];
  wire   wr_known = hit_stat || hit_umsk || hit_ctrl || hit_lim || hit_cnt;

  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // Write response, held until the master takes it
  // A master that never raises bready stalls further writes, by design
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Unmask and control take byte lane 0; the limit takes lanes 0 and 1
  // Lanes 2 and 3 carry nothing here and are dropped without an error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unmask_r  <= UNMASK_RESET;
      control_r <= CONTROL_RESET;
      limit_r   <= CNT_W'(LIMIT_RESET);
    end else begin
      if (wr_lane0 && hit_umsk) begin
        unmask_r <= w_data_r[7:0];
      end
      if (wr_lane0 && hit_ctrl) begin
        control_r <= w_data_r[1:0];
      end
      if (hit_lim && (wr_lane0 || wr_lane1)) begin
        limit_r <= CNT_W'({wr_lane1 ? w_data_r[15:8] : limit_r[15:8],
                           wr_lane0 ? w_data_r[7:0] : limit_r[7:0]});
      end
    end
  end

  assign no_tx_crc     = control_r[BIT_NO_CRC];
  assign receive_reset = control_r[BIT_RX_RESET];

  // ****************************************
  // Transmit byte counter
  // ****************************************
  // The counter only reports; transmit is never halted at the limit,
  // it ends when the FIFO drains, which is outside this block
  // A clear and a byte in the same cycle: the clear wins and that byte goes uncounted
  wire cnt_clr   = wr_lane0 && hit_cnt;
  wire cnt_reach = tx_byte_sent && (count_r + CNT_W'(1) == limit_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (cnt_clr) begin
      count_r <= '0;
    end else if (tx_byte_sent) begin
      count_r <= count_r + CNT_W'(1);
    end
  end

  // ****************************************
  // Status events
  // ****************************************
  // Event inputs come from logic on this clock, so they need no synchroniser
  wire       crc_on = !no_tx_crc;
  logic [7:0] ev;
  logic [7:0] w1c;

  assign ev[BIT_BUSY_CHG]  = channel_busy ^ busy_d_r;
  assign ev[BIT_ANT_SLOT]  = antenna_slot_end;
  assign ev[BIT_MORE_INT]  = 1'b0;
  assign ev[BIT_CNT_REACH] = cnt_reach;
  assign ev[BIT_TX_DONE]   = crc_on ? tx_crc_last_bit : tx_last_data_bit;
  assign ev[BIT_CRC_START] = crc_on && tx_crc_first_bit;
  assign ev[BIT_DELIM]     = delimiter_sent;
  assign ev[BIT_FIFO_AVL]  = 1'b0;

  // A one clears, a zero keeps
  assign w1c = (wr_lane0 && hit_stat) ? w_data_r[7:0] : 8'h00;

  // Set wins over a clear in the same cycle so no event is lost
  always_comb begin
    status_nxt = (status_r & ~w1c) | ev;
    if (receive_reset && !ev[BIT_ANT_SLOT]) begin
      status_nxt[BIT_ANT_SLOT] = 1'b0;
    end
    // Summary tracks the third register live, only it, so a write has no hold
    status_nxt[BIT_MORE_INT] = third_irq_active;
    status_nxt[BIT_FIFO_AVL] = !tx_fifo_full;
  end

  // busy_d_r starts low: a channel already busy at release reports one change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= STATUS_RESET;
      busy_d_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      busy_d_r <= channel_busy;
    end
  end

  // ****************************************
  // Interrupt output
  // ****************************************
  // Masked bits keep their status; the summary uses its own unmask bit
  // Registered, so the line cannot glitch while status bits settle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_r & unmask_r);
    end
  end

  // ****************************************
  // Bus read path
  // ****************************************
  wire        rd_take = s_axi_arvalid && !ar_busy_r;
  wire [5:0]  ra      = s_axi_araddr[7:2];
  logic [31:0] rd_mux;
  logic        rd_ok;

  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    if (ra == STATUS_OFFSET[7:2]) begin
      rd_mux[7:0] = status_r;
    end else if (ra == UNMASK_OFFSET[7:2]) begin
      rd_mux[7:0] = unmask_r;
    end else if (ra == CONTROL_OFFSET[7:2]) begin
      rd_mux[1:0] = control_r;
    end else if (ra == LIMIT_OFFSET[7:2]) begin
      rd_mux[CNT_W-1:0] = limit_r;
    end else if (ra == COUNT_OFFSET[7:2]) begin
      rd_mux[CNT_W-1:0] = count_r;
    end else begin
      rd_ok = 1'b0;
    end
  end

  assign s_axi_arready = !ar_busy_r;

  // Read data is captured once and held until taken
  // Reading is never destructive; a write of ones clears status, and receive reset clears bit 6
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ar_busy_r    <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_take) begin
      ar_busy_r    <= 1'b1;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      ar_busy_r    <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> verilog/tx_irq_pkg.sv
// Package with register map, field positions and reset values of the transmit interrupt block
package tx_irq_pkg;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] STATUS_OFFSET  = 8'h00;
  localparam logic [7:0] UNMASK_OFFSET  = 8'h04;
  localparam logic [7:0] CONTROL_OFFSET = 8'h08;
  localparam logic [7:0] LIMIT_OFFSET   = 8'h0C;
  localparam logic [7:0] COUNT_OFFSET   = 8'h10;
  // ****************************************
  // Status field positions
  // ****************************************
  localparam int BIT_BUSY_CHG  = 7;
  localparam int BIT_ANT_SLOT  = 6;
  localparam int BIT_MORE_INT  = 5;
  localparam int BIT_CNT_REACH = 4;
  localparam int BIT_TX_DONE   = 3;
  localparam int BIT_CRC_START = 2;
  localparam int BIT_DELIM     = 1;
  localparam int BIT_FIFO_AVL  = 0;
  // Control register fields
  localparam int BIT_RX_RESET  = 0;
  localparam int BIT_NO_CRC    = 1;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  STATUS_RESET  = 8'h21;
  localparam logic [7:0]  UNMASK_RESET  = 8'h00;
  localparam logic [1:0]  CONTROL_RESET = 2'h0;
  localparam logic [15:0] LIMIT_RESET   = 16'hFFFF;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage
